//--- logic/sar_adc_pkg.sv
// Constants shared by the converter control logic.
// Assumes a 50 MHz system clock; all timings are converted to cycles here.
package sar_adc_pkg;
	// ************************************************************
	// Timing
	// ************************************************************
	localparam int CLK_PERIOD_NS = 20;
	localparam int CONV_TIME_NS = 200;
	localparam int CONV_CYCLES = CONV_TIME_NS / CLK_PERIOD_NS;
	localparam int RESET_PHASE_TIME_NS = 100;
	localparam int RESET_PHASE_CYCLES = (RESET_PHASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int POWERDOWN_ENTRY_TIME_NS = 1000;
	localparam int POWERDOWN_ENTRY_CYCLES = (POWERDOWN_ENTRY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ABORT_LIMIT_NS = 45;
	localparam int ABORT_LIMIT_CYCLES = ABORT_LIMIT_NS / CLK_PERIOD_NS;
	localparam int INIT_CONVERSIONS = 4;
	// ************************************************************
	// Codes and widths
	// ************************************************************
	localparam int RESULT_WIDTH = 12;
	localparam logic [11:0] ABORT_CODE = 12'hfe0;
	localparam logic [11:0] RESULT_RESET = 12'h000;
	localparam int BYTE_NIBBLE_LSB = 8;
	typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT} conv_state_type;
	typedef enum logic [1:0] {PW_RUN, PW_RESET, PW_POWERDOWN} power_state_type;
endpackage : sar_adc_pkg

//--- logic/sar_adc_parallel_control.sv
// Sampling, conversion, readout, nap and reset control of a 12-bit converter.
// Assumes all inputs synchronous to clk_sys; sample_code comes from the analog core.
`timescale 1ns/100ps
module sar_adc_parallel_control #(
	parameter int CONV_CYCLES = sar_adc_pkg::CONV_CYCLES,
	parameter int RESET_PHASE_CYCLES = sar_adc_pkg::RESET_PHASE_CYCLES,
	parameter int POWERDOWN_ENTRY_CYCLES = sar_adc_pkg::POWERDOWN_ENTRY_CYCLES
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic chip_select_n,
	input wire logic conversion_start_n,
	input wire logic read_n,
	input wire logic byte_select,
	input wire logic nap_enable_n,
	input wire logic powerdown_reset_n,
	input wire logic [11:0] sample_code,
	output logic busy,
	output logic [11:0] result_bus_out,
	output logic [11:0] result_bus_oe,
	output logic sampling,
	output logic napping,
	output logic powered_down,
	output logic data_invalid
);
	// ************************************************************
	// Edge detection
	// ************************************************************
	logic cs_q_reg, cs_q_next, cv_q_reg, cv_q_next;
	logic cv_rise, cv_fall, cs_fall;
	assign cv_rise = conversion_start_n && !cv_q_reg;
	assign cv_fall = !conversion_start_n && cv_q_reg;
	assign cs_fall = !chip_select_n && cs_q_reg;

	function automatic logic [11:0] format_word(input logic [11:0] w, input logic bsel);
		if (bsel) begin
			format_word = {w[3:0], 8'h00};
		end else begin
			format_word = w;
		end
	endfunction : format_word

	// ************************************************************
	// Conversion control
	// ************************************************************
	sar_adc_pkg::conv_state_type st_reg, st_next;
	sar_adc_pkg::power_state_type pw_reg, pw_next;
	logic [7:0] cnt_reg, cnt_next;
	logic [11:0] result_reg, result_next;
	logic busy_reg, busy_next, nap_reg, nap_next;
	logic [2:0] init_reg, init_next;
	logic [15:0] pwcnt_reg, pwcnt_next;
	logic [11:0] out_reg, out_next, oe_reg, oe_next;
	logic in_reset;
	assign in_reset = pw_reg != sar_adc_pkg::PW_RUN;

	always_comb begin
		st_next = st_reg;
		cnt_next = cnt_reg;
		result_next = result_reg;
		busy_next = busy_reg;
		nap_next = nap_reg;
		init_next = init_reg;
		cs_q_next = chip_select_n;
		cv_q_next = conversion_start_n;
		if (in_reset || !powerdown_reset_n) begin
			st_next = sar_adc_pkg::ST_IDLE;
			busy_next = 1'b0;
			nap_next = 1'b0;
			cnt_next = 8'h00;
			result_next = sar_adc_pkg::ABORT_CODE;
			init_next = 3'(sar_adc_pkg::INIT_CONVERSIONS);
		end else begin
			case (st_reg)
				sar_adc_pkg::ST_IDLE: begin
					if ((cv_rise && !chip_select_n) || (cs_fall && conversion_start_n)) begin
						st_next = sar_adc_pkg::ST_SAMPLE;
						nap_next = 1'b0;
					end
				end
				sar_adc_pkg::ST_SAMPLE: begin
					if ((cv_fall && !chip_select_n) || (cs_fall && !conversion_start_n)) begin
						st_next = sar_adc_pkg::ST_CONVERT;
						busy_next = 1'b1;
						cnt_next = 8'h00;
					end
				end
				sar_adc_pkg::ST_CONVERT: begin
					cnt_next = cnt_reg + 8'h01;
					if (cs_fall && conversion_start_n) begin
						busy_next = 1'b0;
						result_next = sar_adc_pkg::ABORT_CODE;
						st_next = sar_adc_pkg::ST_IDLE;
					end else if (cnt_reg == 8'(CONV_CYCLES - 1)) begin
						busy_next = 1'b0;
						result_next = sample_code;
						if (init_reg != 3'h0) begin
							init_next = init_reg - 3'h1;
						end
						if (!chip_select_n && conversion_start_n) begin
							st_next = sar_adc_pkg::ST_SAMPLE;
						end else begin
							st_next = sar_adc_pkg::ST_IDLE;
							nap_next = !nap_enable_n;
						end
					end
				end
				default: st_next = sar_adc_pkg::ST_IDLE;
			endcase
			if (st_reg == sar_adc_pkg::ST_IDLE && nap_enable_n) begin
				nap_next = 1'b0;
			end else if (st_reg == sar_adc_pkg::ST_IDLE && !busy_reg && st_next == sar_adc_pkg::ST_IDLE && !nap_enable_n) begin
				nap_next = 1'b1;
			end
		end
	end

	// ************************************************************
	// Powerdown and reset sequencing
	// ************************************************************
	always_comb begin
		pw_next = pw_reg;
		pwcnt_next = pwcnt_reg;
		if (powerdown_reset_n) begin
			pw_next = sar_adc_pkg::PW_RUN;
			pwcnt_next = 16'h0000;
		end else begin
			if (pw_reg == sar_adc_pkg::PW_RUN) begin
				pw_next = sar_adc_pkg::PW_RESET;
			end else if (pwcnt_reg >= 16'(POWERDOWN_ENTRY_CYCLES)) begin
				pw_next = sar_adc_pkg::PW_POWERDOWN;
			end
			if (pwcnt_reg != 16'hffff) begin
				pwcnt_next = pwcnt_reg + 16'h0001;
			end
		end
	end

	// ************************************************************
	// Output bus
	// ************************************************************
	always_comb begin
		out_next = 12'h000;
		oe_next = 12'h000;
		if (!chip_select_n && !read_n) begin
			out_next = format_word(result_next, byte_select);
			oe_next = 12'hfff;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			st_reg <= sar_adc_pkg::ST_IDLE;
			pw_reg <= sar_adc_pkg::PW_RUN;
			cnt_reg <= 8'h00;
			pwcnt_reg <= 16'h0000;
			result_reg <= sar_adc_pkg::RESULT_RESET;
			busy_reg <= 1'b0;
			nap_reg <= 1'b0;
			init_reg <= 3'(sar_adc_pkg::INIT_CONVERSIONS);
			out_reg <= 12'h000;
			oe_reg <= 12'h000;
			cs_q_reg <= 1'b1;
			cv_q_reg <= 1'b1;
		end else begin
			st_reg <= st_next;
			pw_reg <= pw_next;
			cnt_reg <= cnt_next;
			pwcnt_reg <= pwcnt_next;
			result_reg <= result_next;
			busy_reg <= busy_next;
			nap_reg <= nap_next;
			init_reg <= init_next;
			out_reg <= out_next;
			oe_reg <= oe_next;
			cs_q_reg <= cs_q_next;
			cv_q_reg <= cv_q_next;
		end
	end

	// Sampling flag follows state with no lag: it is registered from st_next, in step with st_reg
	logic samp_reg, pd_reg, inv_reg;
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			samp_reg <= 1'b0;
			pd_reg <= 1'b0;
			inv_reg <= 1'b1;
		end else begin
			samp_reg <= st_next == sar_adc_pkg::ST_SAMPLE;
			pd_reg <= pw_next == sar_adc_pkg::PW_POWERDOWN;
			inv_reg <= init_next != 3'h0;
		end
	end

	assign busy = busy_reg;
	assign result_bus_out = out_reg;
	assign result_bus_oe = oe_reg;
	assign sampling = samp_reg;
	assign napping = nap_reg;
	assign powered_down = pd_reg;
	assign data_invalid = inv_reg;

	// ************************************************************
	// Checks
	// ************************************************************
	property p_busy_rise;
		@(posedge clk_sys) disable iff (rst || !powerdown_reset_n)
		(st_reg == sar_adc_pkg::ST_SAMPLE && cv_fall && !chip_select_n) |=> busy;
	endproperty
	a_busy_rise: assert property (p_busy_rise) else $error("busy did not rise");

	property p_conv_time;
		@(posedge clk_sys) disable iff (rst || !powerdown_reset_n)
		$rose(busy) |-> ##[1:20] !busy;
	endproperty
	a_conv_time: assert property (p_conv_time) else $error("conversion too long");

	property p_bus_off;
		@(posedge clk_sys) disable iff (rst)
		$past(chip_select_n) || $past(read_n) |-> result_bus_oe == 12'h000;
	endproperty
	a_bus_off: assert property (p_bus_off) else $error("bus driven while deselected");

	property p_byte_fmt;
		@(posedge clk_sys) disable iff (rst)
		(result_bus_oe != 12'h000 && $past(byte_select)) |-> result_bus_out[7:0] == 8'h00;
	endproperty
	a_byte_fmt: assert property (p_byte_fmt) else $error("byte mode low bits not zero");

	property p_reset_abort;
		@(posedge clk_sys) disable iff (rst)
		!powerdown_reset_n |=> !busy && result_reg == sar_adc_pkg::ABORT_CODE;
	endproperty
	a_reset_abort: assert property (p_reset_abort) else $error("reset did not abort");

	property p_abort_code;
		@(posedge clk_sys) disable iff (rst || !powerdown_reset_n)
		(st_reg == sar_adc_pkg::ST_CONVERT && cs_fall && conversion_start_n) |=> result_reg == sar_adc_pkg::ABORT_CODE;
	endproperty
	a_abort_code: assert property (p_abort_code) else $error("abort code missing");

	property p_nap_exit;
		@(posedge clk_sys) disable iff (rst)
		sampling |-> !napping;
	endproperty
	a_nap_exit: assert property (p_nap_exit) else $error("napping while sampling");

	property p_wake;
		@(posedge clk_sys) disable iff (rst)
		(powered_down && powerdown_reset_n) |=> !powered_down;
	endproperty
	a_wake: assert property (p_wake) else $error("no wake after reset release");

	property p_reset_phase;
		@(posedge clk_sys) disable iff (rst)
		(pw_reg == sar_adc_pkg::PW_RESET && pwcnt_reg <= 16'(RESET_PHASE_CYCLES)) |-> result_reg == sar_adc_pkg::ABORT_CODE;
	endproperty
	a_reset_phase: assert property (p_reset_phase) else $error("reset phase code missing");

	property p_start_sample;
		@(posedge clk_sys) disable iff (rst || !powerdown_reset_n)
		(st_reg == sar_adc_pkg::ST_IDLE && !in_reset && cv_rise && !chip_select_n) |=> sampling;
	endproperty
	a_start_sample: assert property (p_start_sample) else $error("start rise did not sample");

	property p_cs_sample;
		@(posedge clk_sys) disable iff (rst || !powerdown_reset_n)
		(st_reg == sar_adc_pkg::ST_IDLE && !in_reset && cs_fall && conversion_start_n) |=> sampling;
	endproperty
	a_cs_sample: assert property (p_cs_sample) else $error("select fall did not sample");

	property p_b2b;
		@(posedge clk_sys) disable iff (rst || !powerdown_reset_n)
		(st_reg == sar_adc_pkg::ST_CONVERT && cnt_reg == 8'(CONV_CYCLES - 1) && !chip_select_n
			&& conversion_start_n && !cs_fall) |=> sampling && !busy;
	endproperty
	a_b2b: assert property (p_b2b) else $error("no sampling at conversion end");

	// Abort and back-to-back ends are excluded: neither naps in the next cycle
	property p_nap_enter;
		@(posedge clk_sys) disable iff (rst || !powerdown_reset_n)
		(st_reg == sar_adc_pkg::ST_CONVERT && cnt_reg == 8'(CONV_CYCLES - 1) && !in_reset
			&& (chip_select_n || !conversion_start_n) && !nap_enable_n) |=> napping;
	endproperty
	a_nap_enter: assert property (p_nap_enter) else $error("no nap after conversion");
endmodule : sar_adc_parallel_control

//--- tb/sar_adc_host_model.sv
// Host side model: drives the converter's control pins.
// Assumes the bench calls its tasks from a single process.
`timescale 1ns/100ps
module sar_adc_host_model (
	input wire logic clk_sys,
	output logic chip_select_n,
	output logic conversion_start_n,
	output logic read_n,
	output logic byte_select,
	output logic nap_enable_n,
	output logic powerdown_reset_n
);
	// ************************************************************
	// Pin drivers
	// ************************************************************
	initial begin
		{chip_select_n, conversion_start_n, read_n} = 3'h7;
		{byte_select, nap_enable_n, powerdown_reset_n} = 3'h3;
	end
	// Changes land just after an edge so the design samples them stably
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#2;
	endtask : tick
	task automatic access(input logic cs, input logic rd, input logic b);
		{chip_select_n, read_n, byte_select} = {cs, rd, b};
		tick(2);
	endtask : access
	// Start held high well past the acquisition need, then one clean fall
	task automatic convert();
		conversion_start_n = 1'b1;
		tick(4);
		conversion_start_n = 1'b0;
		tick(1);
	endtask : convert
	// Deliberate abort, only when the bench asks for one; normal flow never does
	task automatic abort_conv();
		conversion_start_n = 1'b1;
		tick(1);
		chip_select_n = 1'b1;
		tick(1);
		chip_select_n = 1'b0;
		tick(2);
	endtask : abort_conv
endmodule : sar_adc_host_model

//--- tb/sar_adc_parallel_control_tb_top.sv
// Self-checking bench of the converter control block.
// Assumes the host model in its own file; results come from a queue model.
`timescale 1ns/100ps
module sar_adc_parallel_control_tb_top;
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_fail++; $display("[ERR] %0t got %h exp %h", $time, a, b); end end
	localparam int CONV = sar_adc_pkg::CONV_CYCLES;
	localparam int PD_ENTRY = sar_adc_pkg::POWERDOWN_ENTRY_CYCLES;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic [11:0] sample_code;
	logic cs_n, start_n, rd_n, byte_sel, nap_n, pwd_n;
	logic busy, sampling, napping, powered_down, data_invalid;
	logic [11:0] bus_out, bus_oe;
	int n_fail = 0;
	int cmp_count = 0;
	int done_count = 0;
	logic [11:0] exp_q[$];
	sar_adc_host_model i_sar_adc_host_model (.clk_sys(clk_sys), .chip_select_n(cs_n),
		.conversion_start_n(start_n), .read_n(rd_n), .byte_select(byte_sel),
		.nap_enable_n(nap_n), .powerdown_reset_n(pwd_n));
	sar_adc_parallel_control i_sar_adc_parallel_control (.clk_sys(clk_sys), .rst(rst), .chip_select_n(cs_n),
		.conversion_start_n(start_n), .read_n(rd_n), .byte_select(byte_sel),
		.nap_enable_n(nap_n), .powerdown_reset_n(pwd_n), .sample_code(sample_code),
		.busy(busy), .result_bus_out(bus_out), .result_bus_oe(bus_oe), .sampling(sampling),
		.napping(napping), .powered_down(powered_down), .data_invalid(data_invalid));
	// ************************************************************
	// Clock, tasks and tests
	// ************************************************************
	initial begin
		forever #10 clk_sys = ~clk_sys;
	end
	task automatic wrap_up();
		$display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : wrap_up
	task automatic read_check();
		logic [11:0] e;
		e = exp_q.pop_front();
		i_sar_adc_host_model.access(1'b0, 1'b0, 1'b0);
		`CHK(bus_oe, 12'hfff)
		`CHK(bus_out, e)
		i_sar_adc_host_model.access(1'b0, 1'b0, 1'b1);
		`CHK(bus_out, {e[3:0], 8'h00})
		i_sar_adc_host_model.access(1'b0, 1'b1, 1'b0);
		`CHK(bus_oe, 12'h000)
	endtask : read_check
	task automatic run_conv();
		int n;
		n = 0;
		sample_code = 12'($urandom);
		i_sar_adc_host_model.convert();
		`CHK(napping, 1'b0)
		`CHK(sampling, 1'b0)
		while (busy !== 1'b1 && n < 4) begin
			i_sar_adc_host_model.tick(1);
			n++;
		end
		n = 0;
		while (busy === 1'b1 && n < 50) begin
			i_sar_adc_host_model.tick(1);
			n++;
		end
		`CHK(n, CONV)
		done_count++;
		i_sar_adc_host_model.tick(1);
		`CHK(data_invalid, 1'(done_count < 4))
		exp_q.push_back(sample_code);
	endtask : run_conv
	initial begin
		repeat (5000) @(posedge clk_sys);
		n_fail++;
		wrap_up();
	end
	initial begin
		void'($urandom(32'h3727));
		sample_code = 12'($urandom);
		repeat (8) @(posedge clk_sys);
		#2 rst = 1'b0;
		i_sar_adc_host_model.access(1'b0, 1'b1, 1'b0);
		`CHK(sampling, 1'b1)
		for (int i = 0; i < 6; i++) begin
			i_sar_adc_host_model.nap_enable_n = (i < 4);
			run_conv();
			read_check();
			`CHK(napping, 1'(i >= 4))
		end
		// Back-to-back: start rises during the conversion, so sampling restarts at its end
		sample_code = 12'($urandom);
		i_sar_adc_host_model.convert();
		i_sar_adc_host_model.conversion_start_n = 1'b1;
		i_sar_adc_host_model.tick(CONV);
		`CHK(busy, 1'b0)
		`CHK(sampling, 1'b1)
		exp_q.push_back(sample_code);
		read_check();
		// Abort mid-conversion: result must carry the abort marker
		i_sar_adc_host_model.convert();
		i_sar_adc_host_model.abort_conv();
		`CHK(busy, 1'b0)
		exp_q.push_back(sar_adc_pkg::ABORT_CODE);
		read_check();
		i_sar_adc_host_model.access(1'b0, 1'b0, 1'b0);
		i_sar_adc_host_model.convert();
		i_sar_adc_host_model.powerdown_reset_n = 1'b0;
		done_count = 0;
		i_sar_adc_host_model.tick(3);
		`CHK(busy, 1'b0)
		`CHK(bus_out, sar_adc_pkg::ABORT_CODE)
		`CHK(data_invalid, 1'b1)
		`CHK(powered_down, 1'b0)
		i_sar_adc_host_model.tick(PD_ENTRY + 2);
		`CHK(powered_down, 1'b1)
		i_sar_adc_host_model.powerdown_reset_n = 1'b1;
		i_sar_adc_host_model.tick(3);
		`CHK(powered_down, 1'b0)
		i_sar_adc_host_model.access(1'b0, 1'b1, 1'b0);
		run_conv();
		read_check();
		wrap_up();
	end
endmodule : sar_adc_parallel_control_tb_top
